// ---- inc/tap_pkg.sv ----
// tap_pkg: shared types and constants for the test access port pin block
// assumes: included before the design; nothing imported, all uses scoped
package tap_pkg;

  // ****************************************
  // tap controller states
  // ****************************************
  typedef enum logic [3:0] {
    test_logic_reset,
    run_test_idle,
    select_dr_scan,
    capture_dr,
    shift_dr,
    exit1_dr,
    pause_dr,
    exit2_dr,
    update_dr,
    select_ir_scan,
    capture_ir,
    shift_ir,
    exit1_ir,
    pause_ir,
    exit2_ir,
    update_ir
  } tap_state_e;

  // ****************************************
  // pin groups
  // ****************************************
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } tap_in_s;

  typedef struct packed {
    logic tdo;
    logic tdo_oe_n;
  } tap_out_s;

  // ****************************************
  // constants
  // ****************************************
  localparam logic PULL_LEVEL = 1'b1;
  localparam int IR_WIDTH_DEFAULT = 4;
  localparam logic [3:0] IR_RESET = 4'h1;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [1:0] IR_CAPTURE = 2'h1;
  localparam logic [3:0] DR_RESET = 4'h0;

endpackage

// ---- verilog/tap_pins.sv ----
// tap_pins: test access port pin logic, controller and bypass/ir shifters
// assumes: tck, tms, tdi and both resets come from off-chip and are sampled on clk
// assumes: the pad outside this block drives tdo while tdo_oe_n is low
`timescale 1ns/1ps
module tap_pins #(
  parameter int IR_WIDTH = tap_pkg::IR_WIDTH_DEFAULT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic tck,
  input wire logic tms,
  input wire logic tms_driven,
  input wire logic tdi,
  input wire logic tdi_driven,
  input wire logic test_port_reset_n,
  input wire logic chip_reset_n,
  output logic tdo,
  output logic tdo_oe_n,
  output tap_pkg::tap_state_e state,
  output logic [IR_WIDTH-1:0] instruction
);

  // ****************************************
  // parameter check
  // ****************************************
  // the reset and bypass codes are of the default width; the capture code is two bits, zero-padded
  if (IR_WIDTH != tap_pkg::IR_WIDTH_DEFAULT) begin : g_width_check
    $error("tap_pins: IR_WIDTH must match the instruction codes");
  end

  // ****************************************
  // input synchronisers
  // ****************************************
  // every pin passes two flops before any logic reads it
  tap_pkg::tap_in_s pin_s1;
  tap_pkg::tap_in_s pin_s2;
  logic tms_driven_s1;
  logic tms_driven_s2;
  logic tdi_driven_s1;
  logic tdi_driven_s2;
  logic port_reset_n_s1;
  logic port_reset_n_s2;
  logic chip_reset_n_s1;
  logic chip_reset_n_s2;

  always_ff @(posedge clk) begin
    pin_s1.tck <= tck;
    pin_s1.tms <= tms;
    pin_s1.tdi <= tdi;
    tms_driven_s1 <= tms_driven;
    tdi_driven_s1 <= tdi_driven;
    port_reset_n_s1 <= test_port_reset_n;
    chip_reset_n_s1 <= chip_reset_n;
    pin_s2 <= pin_s1;
    tms_driven_s2 <= tms_driven_s1;
    tdi_driven_s2 <= tdi_driven_s1;
    port_reset_n_s2 <= port_reset_n_s1;
    chip_reset_n_s2 <= chip_reset_n_s1;
  end

  // ****************************************
  // pull-ups, edge detect and reset merge
  // ****************************************
  tap_pkg::tap_in_s pin;
  logic tck_d;
  logic next_tck_d;
  logic rst_any;
  logic rise;
  logic fall;

  always_comb begin
    next_tck_d = pin_s2.tck;
    pin.tck = pin_s2.tck;
    pin.tms = tms_driven_s2 ? pin_s2.tms : tap_pkg::PULL_LEVEL;
    pin.tdi = tdi_driven_s2 ? pin_s2.tdi : tap_pkg::PULL_LEVEL;
    rise = pin.tck & ~tck_d;
    fall = ~pin.tck & tck_d;
    // neither reset pin waits for a test clock edge
    rst_any = reset | ~port_reset_n_s2 | ~chip_reset_n_s2;
  end

  always_ff @(posedge clk) begin
    tck_d <= next_tck_d;
  end

  // ****************************************
  // controller
  // ****************************************
  function automatic tap_pkg::tap_state_e step(input tap_pkg::tap_state_e s, input logic m);
    case (s)
      tap_pkg::test_logic_reset: step = m ? tap_pkg::test_logic_reset : tap_pkg::run_test_idle;
      tap_pkg::run_test_idle: step = m ? tap_pkg::select_dr_scan : tap_pkg::run_test_idle;
      tap_pkg::select_dr_scan: step = m ? tap_pkg::select_ir_scan : tap_pkg::capture_dr;
      tap_pkg::capture_dr: step = m ? tap_pkg::exit1_dr : tap_pkg::shift_dr;
      tap_pkg::shift_dr: step = m ? tap_pkg::exit1_dr : tap_pkg::shift_dr;
      tap_pkg::exit1_dr: step = m ? tap_pkg::update_dr : tap_pkg::pause_dr;
      tap_pkg::pause_dr: step = m ? tap_pkg::exit2_dr : tap_pkg::pause_dr;
      tap_pkg::exit2_dr: step = m ? tap_pkg::update_dr : tap_pkg::shift_dr;
      tap_pkg::update_dr: step = m ? tap_pkg::select_dr_scan : tap_pkg::run_test_idle;
      tap_pkg::select_ir_scan: step = m ? tap_pkg::test_logic_reset : tap_pkg::capture_ir;
      tap_pkg::capture_ir: step = m ? tap_pkg::exit1_ir : tap_pkg::shift_ir;
      tap_pkg::shift_ir: step = m ? tap_pkg::exit1_ir : tap_pkg::shift_ir;
      tap_pkg::exit1_ir: step = m ? tap_pkg::update_ir : tap_pkg::pause_ir;
      tap_pkg::pause_ir: step = m ? tap_pkg::exit2_ir : tap_pkg::pause_ir;
      tap_pkg::exit2_ir: step = m ? tap_pkg::update_ir : tap_pkg::shift_ir;
      tap_pkg::update_ir: step = m ? tap_pkg::select_dr_scan : tap_pkg::run_test_idle;
      default: step = tap_pkg::test_logic_reset;
    endcase
  endfunction

  logic [IR_WIDTH-1:0] ir_shift;
  logic [IR_WIDTH-1:0] dr_shift;
  tap_pkg::tap_state_e next_state;
  logic [IR_WIDTH-1:0] next_ir_shift;
  logic [IR_WIDTH-1:0] next_instruction;
  logic [IR_WIDTH-1:0] next_dr_shift;

  // ****************************************
  // controller state
  // ****************************************
  always_comb begin
    next_state = state;
    if (rst_any) begin
      next_state = tap_pkg::test_logic_reset;
    end else if (rise) begin
      next_state = step(state, pin.tms);
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  // ****************************************
  // instruction and data shifters
  // ****************************************
  always_comb begin
    next_ir_shift = ir_shift;
    next_instruction = instruction;
    next_dr_shift = dr_shift;
    if (rst_any || state == tap_pkg::test_logic_reset) begin
      next_instruction = tap_pkg::IR_RESET;
    end
    if (!rst_any && rise) begin
      case (state)
        tap_pkg::capture_ir: begin
          next_ir_shift = {{(IR_WIDTH-2){1'b0}}, tap_pkg::IR_CAPTURE};
        end
        tap_pkg::shift_ir: begin
          next_ir_shift = {pin.tdi, ir_shift[IR_WIDTH-1:1]};
        end
        tap_pkg::update_ir: begin
          next_instruction = ir_shift;
        end
        tap_pkg::capture_dr: begin
          next_dr_shift = tap_pkg::DR_RESET;
        end
        tap_pkg::shift_dr: begin
          // bypass is one bit; other instructions use the full register
          if (instruction == tap_pkg::IR_BYPASS) begin
            next_dr_shift = {{(IR_WIDTH-1){1'b0}}, pin.tdi};
          end else begin
            next_dr_shift = {pin.tdi, dr_shift[IR_WIDTH-1:1]};
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    ir_shift <= next_ir_shift;
    instruction <= next_instruction;
    dr_shift <= next_dr_shift;
  end

  // ****************************************
  // output on falling test clock
  // ****************************************
  tap_pkg::tap_out_s out_q;
  tap_pkg::tap_out_s next_out;

  // tdo is enabled on a fall in the two shift states and released on a fall in any other state
  function automatic logic is_shift(input tap_pkg::tap_state_e s);
    is_shift = (s == tap_pkg::shift_ir) || (s == tap_pkg::shift_dr);
  endfunction

  always_comb begin
    next_out = out_q;
    if (rst_any) begin
      next_out.tdo = 1'b0;
      next_out.tdo_oe_n = 1'b1;
    end else if (fall) begin
      next_out.tdo_oe_n = ~is_shift(state);
      if (state == tap_pkg::shift_ir) begin
        next_out.tdo = ir_shift[0];
      end
      if (state == tap_pkg::shift_dr) begin
        next_out.tdo = dr_shift[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    out_q <= next_out;
  end

  // ****************************************
  // pin outputs
  // ****************************************
  // both come straight from the output register
  assign tdo = out_q.tdo;
  assign tdo_oe_n = out_q.tdo_oe_n;

endmodule

// ---- dv/tap_pins_asserts.sv ----
// tap_pins_asserts: pin timing checks for tap_pins
// assumes: bound to tap_pins; test clock phases last several clk cycles
`timescale 1ns/1ps
module tap_pins_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic tck,
  input wire logic test_port_reset_n,
  input wire logic chip_reset_n,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  input wire tap_pkg::tap_state_e state
);
  logic [4:0] h, next_h;
  logic [2:0] q, next_q;
  always_comb begin
    next_h = {h[3:0], tck};
    next_q = (!test_port_reset_n || !chip_reset_n) ? 3'h0 : q + 3'(q != 3'h7);
  end
  always_ff @(posedge clk) begin
    h <= next_h;
    q <= reset ? 3'h0 : next_q;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence quiet_s; q == 3'h7; endsequence
  sequence fell_s; (!h[1] && h[3]) || (!h[2] && h[4]); endsequence
  sequence rose_s; (h[1] && !h[3]) || (h[2] && !h[4]); endsequence
  a_tdo_on_fall: assert property (quiet_s ##0 $changed(tdo) |-> fell_s)
    else $error("tdo moved off a fall");
  a_oe_on_fall: assert property (quiet_s ##0 $changed(tdo_oe_n) |-> fell_s)
    else $error("enable moved off a fall");
  a_oe_only_shift: assert property (!tdo_oe_n |-> state inside {tap_pkg::shift_dr,
    tap_pkg::exit1_dr, tap_pkg::shift_ir, tap_pkg::exit1_ir}) else $error("tdo driven idle");
  a_oe_off_leave: assert property ($rose(tdo_oe_n) |-> !(state inside {tap_pkg::shift_dr,
    tap_pkg::shift_ir})) else $error("tdo released in shift");
  a_test_rst: assert property (!test_port_reset_n [*4] |-> state == 0 && tdo_oe_n)
    else $error("test reset ignored");
  a_chip_rst: assert property (!chip_reset_n [*4] |-> state == 0 && tdo_oe_n)
    else $error("chip reset ignored");
  a_state_on_rise: assert property (quiet_s ##0 $changed(state) |-> rose_s)
    else $error("state moved off a rise");
  a_leave_reset: assert property (quiet_s ##0 $changed(state) && $past(state) == 0
    |-> state == tap_pkg::run_test_idle) else $error("bad step from reset state");
endmodule

// ---- dv/tap_ctl_model.sv ----
// tap_ctl_model: scan controller driving the test pins
// assumes: 125 ns test clock, still between steps; a floating line flips
`timescale 1ns/1ps
module tap_ctl_model (
  output logic tck,
  output logic tms,
  output logic tms_driven,
  output logic tdi,
  output logic tdi_driven
);
  logic fl_ms = 1'b0;
  logic fl_di = 1'b0;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tms_driven = 1'b1;
    tdi = 1'b1;
    tdi_driven = 1'b1;
  end
  // one test clock, ends inside the low phase
  task automatic step(input logic m, input logic d);
    tms = fl_ms ? ~tms : m;
    tms_driven = ~fl_ms;
    tdi = fl_di ? ~tdi : d;
    tdi_driven = ~fl_di;
    #20 tck = 1'b1;
    #65 tck = 1'b0;
    #40;
  endtask
endmodule

// ---- dv/tb_top.sv ----
// tb_top: random scans, floating pins and resets on tap_pins
// assumes: package, checker and controller model compiled first
`timescale 1ns/1ps
module tb_top;
  logic clk, reset, tck, tms, tms_driven, tdi, tdi_driven;
  logic test_port_reset_n, chip_reset_n, tdo, tdo_oe_n;
  logic [3:0] instruction, v;
  logic [7:0] d;
  logic [15:0] x;
  tap_pkg::tap_state_e state;
  int miscompares = 0;
  int compares = 0;
  tap_pins i_dut (.clk, .reset, .tck, .tms, .tms_driven, .tdi, .tdi_driven,
    .test_port_reset_n, .chip_reset_n, .tdo, .tdo_oe_n, .state, .instruction);
  tap_ctl_model i_ctl (.tck, .tms, .tms_driven, .tdi, .tdi_driven);
  always #5 clk = ~clk;
  task automatic cmp(input string n, input logic [3:0] e, input logic [3:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic end_sim();
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // n test clocks, tdo checked where c is set
  task automatic scan(input int n, input logic [15:0] m, t, e, c);
    // keep every pin change and every look at tdo clear of clk edges
    #2.5;
    for (int i = 0; i < n; i++) begin
      i_ctl.step(m[i], t[i]);
      if (c[i]) cmp("tdo", 4'(e[i]), 4'(tdo));
      if (c[i]) cmp("tdo_oe_n", 4'h0, 4'(tdo_oe_n));
    end
    @(negedge clk);
  endtask
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    test_port_reset_n = 1'b0;
    chip_reset_n = 1'b0;
    void'($urandom(89413));
    repeat (10) @(negedge clk);
    reset = 1'b0;
    test_port_reset_n = 1'b1;
    chip_reset_n = 1'b1;
    repeat (4) @(negedge clk);
    cmp("state", tap_pkg::test_logic_reset, state);
    cmp("instruction", tap_pkg::IR_RESET, instruction);
    scan(1, 16'h0, 16'h0, 16'h0, 16'h0);
    for (int k = 0; k < 4; k++) begin
      v = (k == 0) ? 4'he : (k == 3) ? 4'hf : 4'($urandom_range(13));
      d = 8'($urandom);
      x = (k == 3) ? 16'h03f8 : {6'h0, d[3:0], 6'h0};
      i_ctl.fl_di = (k == 3);
      scan(10, 16'h0183, {8'h0, v, 4'h0}, 16'h0008, 16'h0078);
      cmp("instruction", v, instruction);
      cmp("tdo_oe_n", 4'h1, 4'(tdo_oe_n));
      scan(13, 16'h0c01, {5'h0, d, 3'h0}, x, 16'h03fc);
    end
    scan(3, 16'h1, 16'h0, 16'h0, 16'h0);
    i_ctl.fl_ms = 1'b1;
    scan(5, 16'h0, 16'h0, 16'h0, 16'h0);
    cmp("state", tap_pkg::test_logic_reset, state);
    i_ctl.fl_ms = 1'b0;
    for (int k = 0; k < 2; k++) begin
      scan(4, 16'h2, 16'h0, 16'h0, 16'h0);
      test_port_reset_n = (k != 0);
      chip_reset_n = (k == 0);
      repeat (4) @(negedge clk);
      cmp("state", tap_pkg::test_logic_reset, state);
      cmp("tdo_oe_n", 4'h1, 4'(tdo_oe_n));
      test_port_reset_n = 1'b1;
      chip_reset_n = 1'b1;
      repeat (4) @(negedge clk);
    end
    end_sim();
  end
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end
endmodule
bind tap_pins tap_pins_asserts i_chk (.clk, .reset, .tck, .test_port_reset_n, .chip_reset_n,
  .tdo, .tdo_oe_n, .state);
